// file: ess_host_model.sv
// link-side host model: one request at a time, gated link clock
`timescale 1ns/1ps
`default_nettype none
module ess_host_model (
	input  wire logic               linkClk,
	input  wire logic               linkReqReady,
	input  wire logic         [7:0] linkRdData_r,
	input  wire logic               linkRdValid_r,
	output logic                    linkReqStrobe,
	output var ess_pkg::ess_kind_t  linkReqKind,
	output logic              [7:0] linkReqAddr,
	output logic              [7:0] linkReqData,
	output logic                    linkRun
);
	initial begin
		linkReqStrobe = 1'b0;
		linkReqKind = ess_pkg::ESS_K_END;
		linkReqAddr = 8'h00;
		linkReqData = 8'h00;
		linkRun = 1'b0;
	end

	// strobe when ready, then wait for the single answer pulse
	task automatic xfer(input ess_pkg::ess_kind_t k, input logic [7:0] a,
			input logic [7:0] d, output logic [7:0] rd, output logic seen);
		int n;
		seen = 1'b0;
		rd = 8'h00;
		n = 0;
		linkRun = 1'b1;
		@(posedge linkClk);
		#1;
		while (linkReqReady !== 1'b1 && n < 400) begin
			@(posedge linkClk);
			#1;
			n++;
		end
		linkReqStrobe = 1'b1;
		linkReqKind = k;
		linkReqAddr = a;
		linkReqData = d;
		@(posedge linkClk);
		#1;
		// released address and data lines no longer show the last value, kind is kept
		linkReqStrobe = 1'b0;
		linkReqAddr = ~a;
		linkReqData = ~d;
		n = 0;
		while (seen !== 1'b1 && n < 400) begin
			@(posedge linkClk);
			#1;
			if (linkRdValid_r === 1'b1) begin
				seen = 1'b1;
				rd = linkRdData_r;
			end
			n++;
		end
		linkRun = 1'b0;
	endtask
endmodule
`default_nettype wire

// file: ess_mem.sv
// 64 x 8 memory with one write port and a registered read port
`timescale 1ns/1ps
`default_nettype none
`include "ess_regs.svh"
module ess_mem (
	input  wire logic       clk,
	input  wire logic       we,
	input  wire logic [5:0] wIdx,
	input  wire logic [7:0] wData,
	input  wire logic       re,
	input  wire logic [5:0] rIdx,
	output logic      [7:0] rData_r
);
	logic [7:0] cells [0:`ESS_MEM_DEPTH-1];
	// factory contents: blank, with the shipped device address
	initial begin
		for (int i = 0; i < `ESS_MEM_DEPTH; i++) begin
			cells[i] = 8'h00;
		end
		cells[`ESS_IDX_DEVADDR] = {`ESS_DEVADDR_RST, 1'b0};
	end
	// plain always: the factory image above also writes the array
	always @(posedge clk) begin
		if (we) begin
			cells[wIdx] <= wData;
		end
	end
	always_ff @(posedge clk) begin
		if (re) begin
			rData_r <= cells[rIdx];
		end
	end
endmodule
`default_nettype wire

// file: ess_pkg.sv
// types of the shadow and lock block
`default_nettype none
package ess_pkg;
	typedef enum logic [2:0] {
		ESS_K_READ,
		ESS_K_WRITE,
		ESS_K_COPY,
		ESS_K_RECALL,
		ESS_K_LOCK,
		ESS_K_END
	} ess_kind_t;
	typedef enum logic [2:0] {
		ESS_S_BOOT,
		ESS_S_BOOTL,
		ESS_S_IDLE,
		ESS_S_XRD,
		ESS_S_XWR,
		ESS_S_RD1,
		ESS_S_RD2
	} ess_state_t;
endpackage
`default_nettype wire

// file: ess_regs.svh
// register offsets, field positions and reset values of the shadow and lock block
`ifndef ESS_REGS_SVH
`define ESS_REGS_SVH
`define ESS_ADDR_SFR        8'h15
`define ESS_ADDR_NVCTL      8'h1f
`define ESS_ADDR_DEVADDR    8'h7e
`define ESS_BLK0_LO         8'h20
`define ESS_BLK0_HI         8'h2f
`define ESS_BLK1_LO         8'h60
`define ESS_BLK1_HI         8'h7f
`define ESS_COPY_BIT        7
`define ESS_ARM_BIT         6
`define ESS_PLOCK_BIT       1
`define ESS_ULOCK_BIT       0
`define ESS_AWE_BIT         1
`define ESS_DEVADDR_RST     7'h34
`define ESS_IDX_LOCKWORD    6'h1f
`define ESS_IDX_DEVADDR     6'h3e
`define ESS_BLK0_LAST       5'h0f
`define ESS_BLK1_LAST       5'h1f
`define ESS_MEM_DEPTH       64
`endif

// file: ess_shadow_lock.sv
// shadow RAM, copy/recall, block locking and programmable device address
`timescale 1ns/1ps
`default_nettype none
`include "ess_regs.svh"
module ess_shadow_lock (
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic             linkClk,
	input  wire logic             linkReqStrobe,
	input  wire ess_pkg::ess_kind_t linkReqKind,
	input  wire logic       [7:0] linkReqAddr,
	input  wire logic       [7:0] linkReqData,
	output logic                  linkReqReady,
	output logic            [7:0] linkRdData_r,
	output logic                  linkRdValid_r,
	output logic            [6:0] linkDeviceAddr_r
);
	function automatic logic isBlk0(input logic [7:0] a);
		return (a >= `ESS_BLK0_LO) && (a <= `ESS_BLK0_HI);
	endfunction
	function automatic logic isBlk1(input logic [7:0] a);
		return (a >= `ESS_BLK1_LO) && (a <= `ESS_BLK1_HI);
	endfunction
	function automatic logic [5:0] memIdx(input logic [7:0] a);
		return isBlk1(a) ? {1'b1, a[4:0]} : {2'b00, a[3:0]};
	endfunction

	// link domain: request holding and answer capture
	ess_pkg::ess_kind_t lnkKind_r;
	logic [7:0]         lnkAddr_r;
	logic [7:0]         lnkData_r;
	logic               lnkTgl_r;
	logic               lnkBusy_r;
	logic               ackS1_r;
	logic               ackS2_r;
	logic               ackS3_r;
	logic               ackSeen_r;
	logic               ackTgl_r;
	logic [7:0]         ackData_r;
	logic [6:0]         ackAddr_r;
	logic               ackEvt;

	assign linkReqReady = !lnkBusy_r;
	assign ackEvt = (ackS2_r == ackS3_r) && (ackS3_r != ackSeen_r);

	always_ff @(posedge linkClk or negedge reset_n) begin
		if (!reset_n) begin
			lnkKind_r <= ess_pkg::ESS_K_END;
			lnkAddr_r <= 8'h00;
			lnkData_r <= 8'h00;
			lnkTgl_r <= 1'b0;
		end else if (linkReqStrobe && !lnkBusy_r) begin
			lnkKind_r <= linkReqKind;
			lnkAddr_r <= linkReqAddr;
			lnkData_r <= linkReqData;
			lnkTgl_r <= !lnkTgl_r;
		end
	end
	always_ff @(posedge linkClk or negedge reset_n) begin
		if (!reset_n) begin
			ackS1_r <= 1'b0;
			ackS2_r <= 1'b0;
			ackS3_r <= 1'b0;
		end else begin
			ackS1_r <= ackTgl_r;
			ackS2_r <= ackS1_r;
			ackS3_r <= ackS2_r;
		end
	end
	always_ff @(posedge linkClk or negedge reset_n) begin
		if (!reset_n) begin
			lnkBusy_r <= 1'b0;
			ackSeen_r <= 1'b0;
			linkRdValid_r <= 1'b0;
			linkRdData_r <= 8'h00;
			linkDeviceAddr_r <= `ESS_DEVADDR_RST;
		end else begin
			linkRdValid_r <= ackEvt;
			if (linkReqStrobe && !lnkBusy_r) begin
				lnkBusy_r <= 1'b1;
			end else if (ackEvt) begin
				lnkBusy_r <= 1'b0;
			end
			if (ackEvt) begin
				ackSeen_r <= ackS3_r;
				linkRdData_r <= ackData_r;
				linkDeviceAddr_r <= ackAddr_r;
			end
		end
	end

	// core domain: request crossing
	logic               reqS1_r;
	logic               reqS2_r;
	logic               reqS3_r;
	logic               reqSeen_r;
	logic               reqEvt;
	logic               pending_r;
	ess_pkg::ess_kind_t pendKind_r;
	logic [7:0]         pendAddr_r;
	logic [7:0]         pendData_r;
	assign reqEvt = (reqS2_r == reqS3_r) && (reqS3_r != reqSeen_r);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reqS1_r <= 1'b0;
			reqS2_r <= 1'b0;
			reqS3_r <= 1'b0;
		end else begin
			reqS1_r <= lnkTgl_r;
			reqS2_r <= reqS1_r;
			reqS3_r <= reqS2_r;
		end
	end

	// core state
	ess_pkg::ess_state_t state_r;
	logic       copying_r;
	logic       xferCopy_r;
	logic       xferBlk_r;
	logic       xferChain_r;
	logic [4:0] xferCnt_r;
	logic [1:0] lockFlags_r;
	logic       lockArm_r;
	logic       armClosed_r;
	logic       addrWe_r;
	logic [6:0] devAddr_r;
	logic [7:0] rdData_r;
	logic       snapValid_r;
	logic [7:0] snapAddr_r;
	logic [7:0] snap_r;
	logic [7:0] shRData;
	logic [7:0] nvRData;

	logic       isRead, isWrite, inB0, inB1, inSh, snapHit, needPort, svc;
	logic       busShWr, lockWr, ackNow, xferLast;
	logic       shRe, shWe, nvRe, nvWe;
	logic [5:0] shRIdx, shWIdx, nvWIdx, xferIdx;
	logic [7:0] shWData, nvWData, ctlRead;
	logic [1:0] newLocks;

	assign isRead = pending_r && (pendKind_r == ess_pkg::ESS_K_READ);
	assign isWrite = pending_r && (pendKind_r == ess_pkg::ESS_K_WRITE);
	assign inB0 = isBlk0(pendAddr_r);
	assign inB1 = isBlk1(pendAddr_r);
	assign inSh = inB0 || inB1;
	assign snapHit = snapValid_r && (pendAddr_r == snapAddr_r);
	assign needPort = (isRead && inSh && !snapHit) || (pendKind_r == ess_pkg::ESS_K_COPY)
		|| (pendKind_r == ess_pkg::ESS_K_RECALL) || (pendKind_r == ess_pkg::ESS_K_LOCK);
	// during a copy only requests that leave the shadow port alone go ahead
	assign svc = pending_r && ((state_r == ess_pkg::ESS_S_IDLE) || (copying_r && !needPort));
	// locked or copy-time writes never reach the shadow
	assign busShWr = svc && isWrite && !copying_r && ((inB0 && !lockFlags_r[0])
		|| (inB1 && !lockFlags_r[1] && ((pendAddr_r != `ESS_ADDR_DEVADDR) || addrWe_r)));
	assign lockWr = svc && (pendKind_r == ess_pkg::ESS_K_LOCK) && lockArm_r && armClosed_r;
	assign newLocks = lockFlags_r | (pendData_r[0] ? 2'b10 : 2'b01);
	assign ackNow = (svc && !(isRead && inSh && !snapHit)) || (state_r == ess_pkg::ESS_S_RD1);
	assign xferIdx = {xferBlk_r, xferCnt_r};
	assign xferLast = xferCnt_r == (xferBlk_r ? `ESS_BLK1_LAST : `ESS_BLK0_LAST);
	assign ctlRead = {copying_r, lockArm_r, 4'h0, lockFlags_r};

	// memory ports: bus touches shadow plus the cells lock word, transfers move between arrays
	assign shRe = ((state_r == ess_pkg::ESS_S_XRD) && xferCopy_r) || (svc && isRead && inSh && !snapHit)
		|| ((state_r == ess_pkg::ESS_S_RD1) && !pendAddr_r[0]);
	assign shRIdx = (state_r == ess_pkg::ESS_S_XRD) ? xferIdx
		: (state_r == ess_pkg::ESS_S_RD1) ? memIdx(pendAddr_r + 8'h01) : memIdx(pendAddr_r);
	assign shWe = ((state_r == ess_pkg::ESS_S_XWR) && !xferCopy_r) || busShWr;
	assign shWIdx = busShWr ? memIdx(pendAddr_r) : xferIdx;
	assign shWData = busShWr ? pendData_r : nvRData;
	assign nvRe = ((state_r == ess_pkg::ESS_S_XRD) && !xferCopy_r) || (state_r == ess_pkg::ESS_S_BOOT);
	assign nvWe = ((state_r == ess_pkg::ESS_S_XWR) && xferCopy_r) || lockWr;
	assign nvWIdx = lockWr ? `ESS_IDX_LOCKWORD : xferIdx;
	assign nvWData = lockWr ? {6'h00, newLocks} : shRData;

	ess_mem u_shadow (
		.clk     (clk),
		.we      (shWe),
		.wIdx    (shWIdx),
		.wData   (shWData),
		.re      (shRe),
		.rIdx    (shRIdx),
		.rData_r (shRData)
	);
	ess_mem u_cells (
		.clk     (clk),
		.we      (nvWe),
		.wIdx    (nvWIdx),
		.wData   (nvWData),
		.re      (nvRe),
		.rIdx    ((state_r == ess_pkg::ESS_S_BOOT) ? `ESS_IDX_LOCKWORD : xferIdx),
		.rData_r (nvRData)
	);

	// pending request
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pending_r <= 1'b0;
			reqSeen_r <= 1'b0;
			pendKind_r <= ess_pkg::ESS_K_END;
			pendAddr_r <= 8'h00;
			pendData_r <= 8'h00;
		end else if (reqEvt) begin
			pending_r <= 1'b1;
			reqSeen_r <= reqS3_r;
			pendKind_r <= lnkKind_r;
			pendAddr_r <= lnkAddr_r;
			pendData_r <= lnkData_r;
		end else if (svc) begin
			pending_r <= 1'b0;
		end
	end

	// sequencer: boot recall, block transfers, shadow reads
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= ess_pkg::ESS_S_BOOT;
			copying_r <= 1'b0;
			xferCopy_r <= 1'b0;
			xferBlk_r <= 1'b0;
			xferChain_r <= 1'b0;
			xferCnt_r <= 5'h00;
		end else begin
			unique case (state_r)
				ess_pkg::ESS_S_BOOT: state_r <= ess_pkg::ESS_S_BOOTL;
				ess_pkg::ESS_S_BOOTL: begin
					// power-up recall restores last copied contents
					xferCopy_r <= 1'b0;
					xferBlk_r <= 1'b0;
					xferChain_r <= 1'b1;
					xferCnt_r <= 5'h00;
					state_r <= ess_pkg::ESS_S_XRD;
				end
				ess_pkg::ESS_S_IDLE: begin
					if (svc && ((pendKind_r == ess_pkg::ESS_K_COPY)
						|| (pendKind_r == ess_pkg::ESS_K_RECALL))) begin
						xferCopy_r <= pendKind_r == ess_pkg::ESS_K_COPY;
						copying_r <= pendKind_r == ess_pkg::ESS_K_COPY;
						xferBlk_r <= pendData_r[0];
						xferChain_r <= 1'b0;
						xferCnt_r <= 5'h00;
						state_r <= ess_pkg::ESS_S_XRD;
					end else if (svc && isRead && inSh && !snapHit) begin
						state_r <= ess_pkg::ESS_S_RD1;
					end
				end
				ess_pkg::ESS_S_XRD: state_r <= ess_pkg::ESS_S_XWR;
				ess_pkg::ESS_S_XWR: begin
					if (!xferLast) begin
						xferCnt_r <= xferCnt_r + 5'h01;
						state_r <= ess_pkg::ESS_S_XRD;
					end else if (xferChain_r) begin
						xferChain_r <= 1'b0;
						xferBlk_r <= 1'b1;
						xferCnt_r <= 5'h00;
						state_r <= ess_pkg::ESS_S_XRD;
					end else begin
						copying_r <= 1'b0;
						state_r <= ess_pkg::ESS_S_IDLE;
					end
				end
				ess_pkg::ESS_S_RD1: begin
					state_r <= pendAddr_r[0] ? ess_pkg::ESS_S_IDLE : ess_pkg::ESS_S_RD2;
				end
				ess_pkg::ESS_S_RD2: state_r <= ess_pkg::ESS_S_IDLE;
			endcase
		end
	end

	// lock flags, arming and address write enable
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			lockFlags_r <= 2'b00;
			lockArm_r <= 1'b0;
			armClosed_r <= 1'b0;
			addrWe_r <= 1'b0;
		end else begin
			if (state_r == ess_pkg::ESS_S_BOOTL) begin
				lockFlags_r <= lockFlags_r | nvRData[1:0];
			end else if (lockWr) begin
				lockFlags_r <= newLocks;
			end
			if (isWrite && svc && (pendAddr_r == `ESS_ADDR_NVCTL) && pendData_r[`ESS_ARM_BIT]) begin
				lockArm_r <= 1'b1;
				armClosed_r <= 1'b0;
			end else if (svc && lockArm_r && armClosed_r && (pendKind_r != ess_pkg::ESS_K_END)) begin
				lockArm_r <= 1'b0;
				armClosed_r <= 1'b0;
			end else if (svc && lockArm_r && (pendKind_r == ess_pkg::ESS_K_END)) begin
				armClosed_r <= 1'b1;
			end
			if (isWrite && svc && (pendAddr_r == `ESS_ADDR_SFR)) begin
				addrWe_r <= pendData_r[`ESS_AWE_BIT];
			end
		end
	end

	// device address follows every shadow write of its byte
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			devAddr_r <= `ESS_DEVADDR_RST;
		end else if (shWe && (shWIdx == `ESS_IDX_DEVADDR)) begin
			devAddr_r <= shWData[7:1];
		end
	end

	// read data and paired-byte snapshot
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdData_r <= 8'h00;
			snapValid_r <= 1'b0;
			snapAddr_r <= 8'h00;
			snap_r <= 8'h00;
		end else begin
			if (svc && isRead) begin
				if (snapHit) begin
					rdData_r <= snap_r;
				end else if (pendAddr_r == `ESS_ADDR_NVCTL) begin
					rdData_r <= ctlRead;
				end else if (pendAddr_r == `ESS_ADDR_SFR) begin
					rdData_r <= {6'h00, addrWe_r, 1'b0};
				end else begin
					rdData_r <= 8'h00;
				end
			end else if (state_r == ess_pkg::ESS_S_RD1) begin
				rdData_r <= shRData;
			end
			if (state_r == ess_pkg::ESS_S_RD2) begin
				snap_r <= shRData;
				snapAddr_r <= pendAddr_r + 8'h01;
				snapValid_r <= 1'b1;
			end else if (svc && (pendKind_r == ess_pkg::ESS_K_END)) begin
				snapValid_r <= 1'b0;
			end
		end
	end

	// answer toward the link
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ackTgl_r <= 1'b0;
			ackData_r <= 8'h00;
			ackAddr_r <= `ESS_DEVADDR_RST;
		end else if (ackNow) begin
			ackTgl_r <= !ackTgl_r;
			ackData_r <= (state_r == ess_pkg::ESS_S_RD1) ? shRData
				: (snapHit ? snap_r : (pendAddr_r == `ESS_ADDR_NVCTL) ? ctlRead
				: (pendAddr_r == `ESS_ADDR_SFR) ? {6'h00, addrWe_r, 1'b0} : 8'h00);
			ackAddr_r <= (shWe && (shWIdx == `ESS_IDX_DEVADDR)) ? shWData[7:1] : devAddr_r;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	property p_lockSticky;
		lockFlags_r[0] |=> lockFlags_r[0];
	endproperty
	a_lockSticky: assert property (p_lockSticky) else $error("user lock flag cleared");
	property p_lockedNoWrite;
		(busShWr && !shWIdx[5]) |-> !lockFlags_r[0];
	endproperty
	a_lockedNoWrite: assert property (p_lockedNoWrite) else $error("write into locked block");
	property p_readReachesShadow;
		(svc && isRead && inSh && !snapHit) |=> (state_r == ess_pkg::ESS_S_RD1) ##1 $changed(ackTgl_r);
	endproperty
	a_readReachesShadow: assert property (p_readReachesShadow) else $error("shadow read lost");
	property p_copyFlag;
		(state_r == ess_pkg::ESS_S_IDLE && svc && pendKind_r == ess_pkg::ESS_K_COPY)
			|=> copying_r ##[1:70] !copying_r;
	endproperty
	a_copyFlag: assert property (p_copyFlag) else $error("copy flag timing wrong");
	property p_noWriteInCopy;
		shWe |-> !copying_r;
	endproperty
	a_noWriteInCopy: assert property (p_noWriteInCopy) else $error("shadow written during copy");
	property p_armClears;
		(svc && lockArm_r && armClosed_r && pendKind_r != ess_pkg::ESS_K_END) |=> !lockArm_r;
	endproperty
	a_armClears: assert property (p_armClears) else $error("arm bit not cleared");
	property p_lockRead;
		(svc && isRead && pendAddr_r == `ESS_ADDR_NVCTL) |=> rdData_r[1:0] == $past(lockFlags_r);
	endproperty
	a_lockRead: assert property (p_lockRead) else $error("lock flags misread");
	property p_addrTakesEffect;
		(shWe && shWIdx == `ESS_IDX_DEVADDR) |=> devAddr_r == $past(shWData[7:1]);
	endproperty
	a_addrTakesEffect: assert property (p_addrTakesEffect) else $error("address not updated");
	property p_addrGuard;
		(svc && isWrite && pendAddr_r == `ESS_ADDR_DEVADDR && !addrWe_r) |=> $stable(devAddr_r);
	endproperty
	a_addrGuard: assert property (p_addrGuard) else $error("address written while disabled");
	property p_snapHold;
		(svc && isRead && snapHit) |=> rdData_r == $past(snap_r);
	endproperty
	a_snapHold: assert property (p_snapHold) else $error("low byte not from snapshot");
	property p_cellsOnlyByFunction;
		nvWe |-> (copying_r || lockWr);
	endproperty
	a_cellsOnlyByFunction: assert property (p_cellsOnlyByFunction) else $error("cells written by bus");

	c_copyDone: cover property ($fell(copying_r));
	c_lockDone: cover property (lockWr);
	c_addrChange: cover property (shWe && busShWr && shWIdx == `ESS_IDX_DEVADDR);
	c_snapUse: cover property (svc && isRead && snapHit);
endmodule
`default_nettype wire

// file: ess_shadow_lock_tb_top.sv
// testbench of the shadow, lock and device address block
`timescale 1ns/1ps
`default_nettype none
module ess_shadow_lock_tb_top;
	typedef struct packed {
		ess_pkg::ess_kind_t kind;
		logic [7:0]         addr;
		logic [7:0]         data;
		logic               chk;
		logic [7:0]         exp;
	} ess_row_t;
	localparam ess_pkg::ess_kind_t kRd = ess_pkg::ESS_K_READ;
	localparam ess_pkg::ess_kind_t kWr = ess_pkg::ESS_K_WRITE;
	localparam ess_pkg::ess_kind_t kEnd = ess_pkg::ESS_K_END;
	localparam ess_pkg::ess_kind_t kCopy = ess_pkg::ESS_K_COPY;
	localparam ess_pkg::ess_kind_t kLock = ess_pkg::ESS_K_LOCK;

	logic               clk = 1'b0;
	logic               reset_n = 1'b0;
	logic               linkClk = 1'b0;
	logic               linkRun;
	logic               linkReqStrobe;
	ess_pkg::ess_kind_t linkReqKind;
	logic         [7:0] linkReqAddr;
	logic         [7:0] linkReqData;
	wire logic          linkReqReady;
	wire logic    [7:0] linkRdData_r;
	wire logic          linkRdValid_r;
	wire logic    [6:0] linkDeviceAddr_r;
	int                 mismatches = 0;
	int                 total_checks = 0;
	int                 cycles = 0;

	ess_row_t rows [0:12] = '{
		'{kRd, 8'h1f, 8'h00, 1'b1, 8'h00},
		'{kRd, 8'h15, 8'h00, 1'b1, 8'h00},
		'{kRd, 8'h7e, 8'h00, 1'b1, 8'h68},
		'{kWr, 8'h20, 8'ha5, 1'b0, 8'h00},
		'{kRd, 8'h20, 8'h00, 1'b1, 8'ha5},
		'{kWr, 8'h2f, 8'h5a, 1'b0, 8'h00},
		'{kRd, 8'h2f, 8'h00, 1'b1, 8'h5a},
		'{kWr, 8'h7e, 8'h55, 1'b0, 8'h00},
		'{kRd, 8'h7e, 8'h00, 1'b1, 8'h68},
		'{kRd, 8'h40, 8'h00, 1'b1, 8'h00},
		'{kRd, 8'hff, 8'h00, 1'b1, 8'h00},
		'{kWr, 8'h62, 8'h12, 1'b0, 8'h00},
		'{kWr, 8'h63, 8'h34, 1'b0, 8'h00}
	};

	always #12.5 clk = ~clk;
	always #62.5 linkClk = (linkRun || !reset_n) ? ~linkClk : 1'b0;

	ess_shadow_lock ess_shadow_lock_inst (
		.clk              (clk),
		.reset_n          (reset_n),
		.linkClk          (linkClk),
		.linkReqStrobe    (linkReqStrobe),
		.linkReqKind      (linkReqKind),
		.linkReqAddr      (linkReqAddr),
		.linkReqData      (linkReqData),
		.linkReqReady     (linkReqReady),
		.linkRdData_r     (linkRdData_r),
		.linkRdValid_r    (linkRdValid_r),
		.linkDeviceAddr_r (linkDeviceAddr_r)
	);

	ess_host_model ess_host_model_inst (
		.linkClk       (linkClk),
		.linkReqReady  (linkReqReady),
		.linkRdData_r  (linkRdData_r),
		.linkRdValid_r (linkRdValid_r),
		.linkReqStrobe (linkReqStrobe),
		.linkReqKind   (linkReqKind),
		.linkReqAddr   (linkReqAddr),
		.linkReqData   (linkReqData),
		.linkRun       (linkRun)
	);

	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			mismatches++;
			$display("[FAIL] run length expected done seen running");
			end_sim();
		end
	end

	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic op(input ess_pkg::ess_kind_t k, input logic [7:0] a, input logic [7:0] d,
			output logic [7:0] rd);
		logic seen;
		ess_host_model_inst.xfer(k, a, d, rd, seen);
		check("answer", 8'h01, {7'h00, seen});
		check("ready after answer", 8'h01, {7'h00, linkReqReady});
	endtask

	task automatic cmd(input ess_pkg::ess_kind_t k, input logic [7:0] a, input logic [7:0] d,
			output logic [7:0] rd);
		logic [7:0] dummy;
		op(k, a, d, rd);
		op(kEnd, 8'h00, 8'h00, dummy);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] rd;
		cmd(kWr, a, d, rd);
	endtask

	task automatic rdchk(input string name, input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] rd;
		cmd(kRd, a, 8'h00, rd);
		check(name, exp, rd);
	endtask

	task automatic wait_copy();
		logic [7:0] rd;
		logic [7:0] dummy;
		int n;
		rd = 8'h80;
		n = 0;
		while (rd[7] !== 1'b0 && n < 60) begin
			op(kRd, 8'h1f, 8'h00, rd);
			n++;
		end
		op(kEnd, 8'h00, 8'h00, dummy);
		check("copy flag clear", 8'h00, rd & 8'h80);
	endtask

	task automatic do_reset();
		@(posedge clk);
		#1;
		reset_n = 1'b0;
		repeat (4) @(posedge clk);
		#1;
		reset_n = 1'b1;
	endtask

	initial begin
		logic [7:0] rd;
		do_reset();
		check("addr at reset", 8'h34, {1'b0, linkDeviceAddr_r});
		foreach (rows[i]) begin
			cmd(rows[i].kind, rows[i].addr, rows[i].data, rd);
			if (rows[i].chk) check("row read", rows[i].exp, rd);
		end
		// pair snapshot held until end of command, then recall of block 1
		op(kRd, 8'h62, 8'h00, rd);
		check("pair high", 8'h12, rd);
		op(kWr, 8'h63, 8'h99, rd);
		op(kRd, 8'h63, 8'h00, rd);
		check("pair low held", 8'h34, rd);
		op(kEnd, 8'h00, 8'h00, rd);
		rdchk("pair low new", 8'h63, 8'h99);
		wr(8'h61, 8'h11);
		cmd(ess_pkg::ESS_K_RECALL, 8'h00, 8'h01, rd);
		rdchk("recalled", 8'h61, 8'h00);
		// device address change, lost on reset without copy
		wr(8'h15, 8'h02);
		rdchk("addr enable", 8'h15, 8'h02);
		wr(8'h7e, 8'h54);
		check("new addr", 8'h2a, {1'b0, linkDeviceAddr_r});
		wr(8'h15, 8'h00);
		do_reset();
		rdchk("addr restored", 8'h7e, 8'h68);
		check("live addr", 8'h34, {1'b0, linkDeviceAddr_r});
		rdchk("user cells", 8'h20, 8'h00);
		// copy keeps the address and the block
		wr(8'h15, 8'h02);
		wr(8'h7e, 8'h54);
		wr(8'h15, 8'h00);
		wr(8'h64, 8'hc6);
		op(kCopy, 8'h00, 8'h01, rd);
		op(kRd, 8'h1f, 8'h00, rd);
		check("copy flag set", 8'h80, rd & 8'h80);
		op(kEnd, 8'h00, 8'h00, rd);
		wait_copy();
		op(kCopy, 8'h00, 8'h01, rd);
		op(kWr, 8'h21, 8'h77, rd);
		op(kEnd, 8'h00, 8'h00, rd);
		wait_copy();
		rdchk("write in copy", 8'h21, 8'h00);
		do_reset();
		rdchk("addr kept", 8'h7e, 8'h54);
		check("live addr kept", 8'h2a, {1'b0, linkDeviceAddr_r});
		rdchk("block copied", 8'h64, 8'hc6);
		// arming then another command, then a real lock
		wr(8'h20, 8'hc3);
		wr(8'h1f, 8'h40);
		wr(8'h20, 8'hc3);
		cmd(kLock, 8'h00, 8'h00, rd);
		rdchk("no lock", 8'h1f, 8'h00);
		wr(8'h1f, 8'h40);
		cmd(kLock, 8'h00, 8'h00, rd);
		rdchk("user locked", 8'h1f, 8'h01);
		wr(8'h20, 8'h3c);
		rdchk("locked write", 8'h20, 8'hc3);
		wr(8'h1f, 8'h40);
		cmd(kLock, 8'h00, 8'h01, rd);
		wr(8'h64, 8'h00);
		rdchk("param locked", 8'h64, 8'hc6);
		wr(8'h1f, 8'h00);
		do_reset();
		rdchk("locks kept", 8'h1f, 8'h03);
		rdchk("locked read", 8'h64, 8'hc6);
		end_sim();
	end
endmodule
`default_nettype wire
